// [bench/prog_host.sv]
// Programmer model driving the serial programming pins
`timescale 1ns/1ps
module prog_host
(
  // Clock
  input wire logic clk_sys,
  // Programming pins
  output logic prog_reset,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // Wait n system clocks, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Enter programming with reset held, sck low for 64 clocks
  task automatic enter();
    prog_reset = 1'b1;
    sck = 1'b0;
    tick(64);
  endtask
  // One byte each way, MSB first, 16 clocks per bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi = tx[i];
      tick(8);
      sck = 1'b1;
      rx[i] = sdo;
      tick(8);
      sck = 1'b0;
    end
  endtask
  // Pins idle at time zero
  initial
  begin
    prog_reset = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the serial flash programming port
`timescale 1ns/1ps
`include "flash_port_map.svh"
module tb_top;
  import flash_port_pkg::*;
  localparam int ERASE_N = 50;
  localparam int WRITE_N = 20;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic prog_reset, sck, sdi, sdo, mem_we, busy;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, rx;
  lock_mode_t lock_mode;
  int num_errors = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  // ----------------------------
  // Clock, memory, design and programmer
  // ----------------------------
  always #2 clk_sys = ~clk_sys;
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A; // Content follows position
  flash_port #(.ERASE_CYCLES(ERASE_N), .WRITE_CYCLES(WRITE_N)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .prog_reset(prog_reset), .sck(sck), .sdi(sdi), .sdo(sdo), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_rdata), .lock_mode(lock_mode), .busy(busy));
  prog_host PROG (.clk_sys(clk_sys), .prog_reset(prog_reset), .sck(sck), .sdi(sdi), .sdo(sdo));
  // Compare and count
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Each page write lands at the next ascending position
  always @(negedge clk_sys)
    if (mem_we === 1'b1)
    begin
      check("write addr", mem_addr, {4'h3, wr_cnt[7:0]});
      check("write data", {4'h0, mem_wdata}, {4'h0, wr_cnt[7:0] ^ 8'h3C});
      wr_cnt <= wr_cnt + 1;
    end
  // Wait for the timer under a bound
  task automatic wait_idle(input int lim);
    for (int n = 0; n < lim && busy !== 1'b0; n++)
      PROG.tick(1);
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_write();
    PROG.xfer(`CMD_PAGE_WRITE, rx);
    PROG.xfer(8'h03, rx);
    for (int p = 0; p < 256; p++)
      PROG.xfer(p[7:0] ^ 8'h3C, rx);
    check("busy write", {11'h0, busy}, 12'h1);
    wait_idle(WRITE_N);
    check("busy write end", {11'h0, busy}, 12'h0);
    check("write count", wr_cnt[11:0], 12'h100);
    $display("test page write done");
  endtask
  task automatic t_read();
    PROG.xfer(`CMD_PAGE_READ, rx);
    PROG.xfer(8'h03, rx);
    for (int p = 0; p < 256; p++)
    begin
      PROG.xfer(8'h00, rx);
      check("read data", {4'h0, rx}, {4'h0, p[7:0] ^ 8'h5A});
    end
    check("no write in read", wr_cnt[11:0], 12'h100);
    $display("test page read done");
  endtask
  task automatic t_lock();
    for (int m = 0; m < 4; m++)
    begin
      PROG.xfer(`CMD_LOCK_TOP, rx);
      PROG.xfer(8'h00, rx);
      PROG.xfer(m[7:0], rx);
      PROG.tick(4);
      check("lock mode", {10'h0, lock_mode}, m[11:0]);
    end
    $display("test lock done");
  endtask
  task automatic t_erase();
    PROG.xfer(8'h80, rx);
    PROG.xfer(8'h00, rx);
    PROG.xfer(8'h00, rx);
    check("busy erase", {11'h0, busy}, 12'h1);
    wait_idle(ERASE_N);
    check("busy erase end", {11'h0, busy}, 12'h0);
    $display("test erase done");
  endtask
  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check("reset lock", {10'h0, lock_mode}, 12'h0);
    check("reset busy", {11'h0, busy}, 12'h0);
    PROG.enter();
    t_write();
    t_read();
    t_lock();
    t_erase();
    print_verdict();
  end
  // Watchdog
  initial
  begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule

// [inc/flash_port_map.svh]
// Constants for the serial flash programming port
`ifndef FLASH_PORT_MAP_SVH
`define FLASH_PORT_MAP_SVH
`define CMD_PAGE_READ 8'h30
`define CMD_PAGE_WRITE 8'h50
`define CMD_LOCK_TOP 8'hAC
`define LOCK_SEL_UPPER_POS 1
`define LOCK_SEL_LOWER_POS 0
`define PAGE_LAST 8'hFF
`define CLK_PERIOD_NS 4
`define ERASE_MS 500
`define ERASE_CYC (`ERASE_MS * 1000000 / `CLK_PERIOD_NS)
`define WRITE_CLKS 64
`define WRITE_US 400
`define WRITE_CYC (`WRITE_CLKS + `WRITE_US * 1000 / `CLK_PERIOD_NS)
`endif

// [inc/flash_port_pkg.sv]
// Types for the serial flash programming port
package flash_port_pkg;
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_ARG = 3'b011,
    ST_BUSY = 3'b100
  } seq_state_t;
  typedef enum logic [1:0] {
    LOCK_NONE = 2'b00,
    LOCK_ONE = 2'b01,
    LOCK_TWO = 2'b10,
    LOCK_THREE = 2'b11
  } lock_mode_t;
endpackage

// [rtl/flash_port.sv]
// Serial flash programming port: bit shifter, page sequencer and write timer
// Contract
// - Lock select bits pick none, level one, two or three protection.
// - Enable sequence accepted with reset held high, no pulse needed.
// - Page data covers byte positions 0 to 255 ascending.
// - After command and upper address, next 256 bytes are data.
// - After last page byte the next byte is decoded as command.
// - Chip erase finishes within 500 ms.
// - Byte write finishes within 64 clocks plus 400 us.
// - Command 0x30 reads a page, 0x50 writes a page.
`timescale 1ns/1ps
`include "flash_port_map.svh"
module flash_port
#(
  parameter int ERASE_CYCLES = `ERASE_CYC,
  parameter int WRITE_CYCLES = `WRITE_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Programming pins
  input wire logic prog_reset,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  // Memory side
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata,
  // Status
  output flash_port_pkg::lock_mode_t lock_mode,
  output logic busy
);
  import flash_port_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sck_s_r, sdi_s_r, rst_s_r;
  logic sck_d_r;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_s_r <= 2'h0;
      sdi_s_r <= 2'h0;
      rst_s_r <= 2'h0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sck_s_r <= {sck_s_r[0], sck};
      sdi_s_r <= {sdi_s_r[0], sdi};
      rst_s_r <= {rst_s_r[0], prog_reset};
      sck_d_r <= sck_s_r[1];
    end
  end
  logic sck_rise, sck_fall, active;
  assign sck_rise = sck_s_r[1] & ~sck_d_r;
  assign sck_fall = ~sck_s_r[1] & sck_d_r;
  assign active = rst_s_r[1]; // Level only, no pulse needed

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_t state_r, state_nxt;
  logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt, out_r, out_nxt, pos_r, pos_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [3:0] page_r, page_nxt;
  logic sdo_r, sdo_nxt, we_r, we_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [27:0] tmr_r, tmr_nxt;
  lock_mode_t lock_r, lock_nxt;
  logic [7:0] byte_in;
  logic byte_done;
  assign byte_in = {sh_r[6:0], sdi_s_r[1]}; // MSB first
  assign byte_done = active && sck_rise && (bit_r == 3'h7);

  always_comb
  begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    cmd_nxt = cmd_r;
    out_nxt = out_r;
    pos_nxt = pos_r;
    bit_nxt = bit_r;
    page_nxt = page_r;
    sdo_nxt = sdo_r;
    we_nxt = 1'b0;
    wd_nxt = wd_r;
    tmr_nxt = tmr_r;
    lock_nxt = lock_r;
    if (!active)
    begin
      state_nxt = ST_CMD;
      bit_nxt = 3'h0;
      sdo_nxt = 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        sh_nxt = byte_in; // Sample on rising edge
        bit_nxt = 3'(bit_r + 3'h1);
      end
      if (sck_fall)
      begin
        sdo_nxt = out_r[7]; // Update on falling edge
        out_nxt = {out_r[6:0], 1'b0};
      end
      if (sck_fall && bit_r == 3'h0 && state_r == ST_DATA && cmd_r == `CMD_PAGE_READ)
      begin
        sdo_nxt = mem_rdata[7];
        out_nxt = {mem_rdata[6:0], 1'b0};
      end
      // Countdown that holds at zero; a load in the decoder below takes over
      if (state_r != ST_BUSY && tmr_r != 28'h0)
        tmr_nxt = 28'(tmr_r - 28'h1);
      unique case (state_r)
        ST_CMD:
          if (byte_done)
          begin
            cmd_nxt = byte_in;
            state_nxt = ST_ADDR;
          end
        ST_ADDR:
          if (byte_done)
          begin
            page_nxt = byte_in[3:0];
            pos_nxt = 8'h00; // Page data starts at byte zero
            if (cmd_r == `CMD_PAGE_READ || cmd_r == `CMD_PAGE_WRITE)
              state_nxt = ST_DATA;
            else
              state_nxt = ST_ARG;
          end
        ST_DATA:
          if (byte_done)
          begin
            if (cmd_r == `CMD_PAGE_WRITE)
            begin
              we_nxt = 1'b1;
              wd_nxt = byte_in;
            end
            pos_nxt = 8'(pos_r + 8'h01); // Ascending positions
            if (pos_r == `PAGE_LAST)
              state_nxt = ST_CMD; // Back to decoding
          end
        ST_ARG:
          if (byte_done)
          begin
            if (cmd_r == `CMD_LOCK_TOP)
            begin
              lock_nxt = lock_mode_t'({byte_in[`LOCK_SEL_UPPER_POS], byte_in[`LOCK_SEL_LOWER_POS]});
              state_nxt = ST_CMD;
            end
            else
            begin
              tmr_nxt = 28'(ERASE_CYCLES);
              state_nxt = ST_BUSY;
            end
          end
        ST_BUSY:
          if (tmr_r == 28'h0)
            state_nxt = ST_CMD;
          else
            tmr_nxt = 28'(tmr_r - 28'h1);
        default:
          state_nxt = ST_CMD; // Unused state codes fall back to decoding
      endcase
      if (we_nxt)
        tmr_nxt = 28'(WRITE_CYCLES); // Byte write time
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_CMD;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      out_r <= 8'h00;
      pos_r <= 8'h00;
      bit_r <= 3'h0;
      page_r <= 4'h0;
      sdo_r <= 1'b0;
      we_r <= 1'b0;
      wd_r <= 8'h00;
      tmr_r <= 28'h0;
      lock_r <= LOCK_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      out_r <= out_nxt;
      pos_r <= pos_nxt;
      bit_r <= bit_nxt;
      page_r <= page_nxt;
      sdo_r <= sdo_nxt;
      we_r <= we_nxt;
      wd_r <= wd_nxt;
      tmr_r <= tmr_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic [11:0] addr_r, addr_nxt;
  logic busy_r, busy_nxt;
  // Address and busy flag computed ahead so both leave from flip-flops
  always_comb
  begin
    addr_nxt = we_nxt ? {page_r, pos_r} : {page_nxt, pos_nxt}; // Write lands at the old position
    busy_nxt = (tmr_nxt != 28'h0) || (state_nxt == ST_BUSY);
  end
  // Register address and busy flag
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_r <= 12'h000;
      busy_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      busy_r <= busy_nxt;
    end
  end
  assign sdo = sdo_r;
  assign mem_we = we_r;
  assign mem_wdata = wd_r;
  assign mem_addr = addr_r;
  assign lock_mode = lock_r;
  assign busy = busy_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  page_return_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_DATA && byte_done && pos_r == `PAGE_LAST) |=> state_r == ST_CMD)
    else $error("page did not end after byte 255");
  page_enter_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_ADDR && byte_done && (cmd_r == `CMD_PAGE_READ || cmd_r == `CMD_PAGE_WRITE))
    |=> (state_r == ST_DATA && pos_r == 8'h00))
    else $error("page data phase not entered at zero");
  pos_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_DATA && byte_done && pos_r != `PAGE_LAST) |=> pos_r == $past(pos_r) + 8'h01)
    else $error("page position not ascending");
  lock_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_ARG && byte_done && cmd_r == `CMD_LOCK_TOP)
    |=> lock_r == lock_mode_t'({$past(byte_in[1]), $past(byte_in[0])}))
    else $error("lock mode mismatch");
  write_time_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    we_r |-> tmr_r == 28'(WRITE_CYCLES))
    else $error("write timer not loaded");
  sample_msb_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (active && sck_rise) |=> sh_r[0] == $past(sdi_s_r[1]))
    else $error("data in not shifted on rising edge");
  level_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!active) |=> (state_r == ST_CMD && bit_r == 3'h0))
    else $error("port not idle without reset level");
  erase_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_ARG && byte_done && cmd_r != `CMD_LOCK_TOP) |=> tmr_r == 28'(ERASE_CYCLES))
    else $error("erase timer not loaded");
  page_write_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_r == ST_DATA && cmd_r == `CMD_PAGE_WRITE && pos_r == `PAGE_LAST);
  page_read_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_r == ST_DATA && cmd_r == `CMD_PAGE_READ && pos_r == `PAGE_LAST);
  lock_c: cover property (@(posedge clk_sys) disable iff (!resetn) lock_r == LOCK_THREE);
endmodule
